//--- core/stream_adapt_pkg.sv
/*
 * Shared constants and adaptation modes for the streaming ready/valid timing adapter.
 * Assumes one clock domain and a single upstream source and downstream sink.
 */
package stream_adapt_pkg;
   // payload field widths
   localparam int DATA_W = 32;
   localparam int CHANNEL_W = 8;
   localparam int EMPTY_W = 2;
   localparam int ERROR_W = 1;
   localparam int PAY_W = DATA_W + CHANNEL_W + EMPTY_W + ERROR_W + 2;
   // longest ready latency handled, and compensation storage bounds
   localparam int MAX_LAT = 8;
   localparam int PTR_W = 3;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
   localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;

   // how the two handshakes are joined; gray-coded
   typedef enum logic [2:0] {
      MODE_PASS   = 3'b000,
      MODE_TIE    = 3'b001,
      MODE_LOSSY  = 3'b011,
      MODE_DELAY  = 3'b010,
      MODE_BUFFER = 3'b110
   } mode_e;
endpackage

//--- core/stream_ready_latency_adapter.sv
/*
 * Streaming timing adapter: joins one upstream source to one downstream sink whose
 * ready/valid capabilities or ready latencies differ; all other signals are payload.
 * Assumes both ports share ref_clk and that each party keeps its own ready latency.
 */
// How it works
// - all non-handshake signals pass from input to output as payload
// - source has ready, sink has none: source ready held at one
// - sink has ready, source ignores it: flag each beat the sink refuses
// - sink latency larger: ready delayed by the latency difference in registers
// - sink latency smaller: buffer of depth equal to the difference absorbs beats
// - handshake lines unused by both sides are tied to a constant
// - valid is generated or dropped when one side lacks it
// - one sink port upstream, one source port downstream, point to point
// - ready latency is the fixed cycle count from ready to data
// - an interface without valid carries valid data every cycle
// - channel field up to eight bits, zero when channels are unused
`timescale 1ns/10ps
module stream_ready_latency_adapter
   import stream_adapt_pkg::*;
#(
   parameter bit IN_HAS_READY = 1'b1,
   parameter bit IN_HAS_VALID = 1'b1,
   parameter int IN_READY_LATENCY = 0,
   parameter bit OUT_HAS_READY = 1'b1,
   parameter bit OUT_HAS_VALID = 1'b1,
   parameter int OUT_READY_LATENCY = 0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // upstream sink port
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [DATA_W-1:0] in_data,
   input wire logic [CHANNEL_W-1:0] in_channel,
   input wire logic in_startofpacket,
   input wire logic in_endofpacket,
   input wire logic [EMPTY_W-1:0] in_empty,
   input wire logic [ERROR_W-1:0] in_error,
   // downstream source port
   output logic out_valid,
   input wire logic out_ready,
   output logic [DATA_W-1:0] out_data,
   output logic [CHANNEL_W-1:0] out_channel,
   output logic out_startofpacket,
   output logic out_endofpacket,
   output logic [EMPTY_W-1:0] out_empty,
   output logic [ERROR_W-1:0] out_error,
   // loss indication
   output logic data_lost_r
);
   localparam mode_e MODE =
      (IN_HAS_READY && !OUT_HAS_READY) ? MODE_TIE :
      (!IN_HAS_READY && OUT_HAS_READY) ? MODE_LOSSY :
      (!IN_HAS_READY && !OUT_HAS_READY) ? MODE_PASS :
      (OUT_READY_LATENCY >= IN_READY_LATENCY) ? MODE_DELAY : MODE_BUFFER;
   localparam int LAT_DIFF = (OUT_READY_LATENCY >= IN_READY_LATENCY) ?
      OUT_READY_LATENCY - IN_READY_LATENCY : IN_READY_LATENCY - OUT_READY_LATENCY;
   localparam logic [CNT_W-1:0] BUF_DEPTH = CNT_W'(LAT_DIFF);

   logic [MAX_LAT-1:0] rdy_sr_r;
   logic [MAX_LAT-1:0] grant_sr_r;
   logic [PAY_W-1:0] buf_r [MAX_LAT];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] pend;
   logic [CNT_W-1:0] settle_r;
   logic in_beat;
   logic sink_win;
   logic push;
   logic pop;
   logic [PAY_W-1:0] in_pay;

   // out_ready as seen k cycles ago; k = 0 is the live value
   function automatic logic ready_tap(input logic live, input logic [MAX_LAT-1:0] sr,
                                      input int k);
      ready_tap = (k == 0) ? live : sr[k-1];
   endfunction

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(LAT_DIFF - 1)) ? PTR_RESET : p + PTR_W'(1);
   endfunction

   assign in_beat = IN_HAS_VALID ? in_valid : 1'b1;
   assign in_pay = {in_channel, in_startofpacket, in_endofpacket, in_empty, in_error, in_data};
   // the cycle in which the sink takes data, given its own latency
   assign sink_win = ready_tap(out_ready, rdy_sr_r, OUT_READY_LATENCY);

   // ready history of the sink, shared by the delay path and the window checks
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdy_sr_r <= '0;
      end else begin
         rdy_sr_r <= {rdy_sr_r[MAX_LAT-2:0], out_ready};
      end
   end

   // grants handed upstream, still on their way back as beats
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         grant_sr_r <= '0;
      end else begin
         grant_sr_r <= {grant_sr_r[MAX_LAT-2:0], in_ready};
      end
   end

   // edges since reset, saturating; checks that look back through the chain wait for it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         settle_r <= CNT_RESET;
      end else if (settle_r != CNT_W'(MAX_LAT)) begin
         settle_r <= settle_r + CNT_W'(1);
      end
   end

   always_comb begin
      pend = CNT_RESET;
      for (int i = 0; i < MAX_LAT; i++) begin
         if (i < IN_READY_LATENCY && grant_sr_r[i]) begin
            pend = pend + CNT_W'(1);
         end
      end
   end

   // upstream ready, by mode
   always_comb begin
      case (MODE)
         MODE_TIE: in_ready = 1'b1;
         MODE_DELAY: in_ready = ready_tap(out_ready, rdy_sr_r, LAT_DIFF);
         // credit held back so beats already requested always find room
         MODE_BUFFER: in_ready = out_ready && (count_r + pend < BUF_DEPTH);
         default: in_ready = 1'b1;
      endcase
   end

   assign push = (MODE == MODE_BUFFER) && in_beat;
   assign pop = (MODE == MODE_BUFFER) && sink_win && (count_r != CNT_RESET);

   // compensation buffer; a limitation is that a depth of one passes at most one beat every three cycles
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_ptr_r <= PTR_RESET;
         rd_ptr_r <= PTR_RESET;
         count_r <= CNT_RESET;
      end else begin
         if (push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         end
         count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
      end
   end

   // storage carries no reset: stale entries are never read once count is zero
   always_ff @(posedge ref_clk) begin
      if (push) begin
         buf_r[wr_ptr_r] <= in_pay;
      end
   end

   // payload and valid toward the sink
   always_comb begin
      if (MODE == MODE_BUFFER) begin
         {out_channel, out_startofpacket, out_endofpacket, out_empty, out_error, out_data} =
            buf_r[rd_ptr_r];
         out_valid = pop;
      end else begin
         {out_channel, out_startofpacket, out_endofpacket, out_empty, out_error, out_data} =
            in_pay;
         out_valid = in_beat;
      end
   end

   // a beat offered outside the sink's window is gone; flag it one cycle later
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         data_lost_r <= 1'b0;
      end else begin
         data_lost_r <= (MODE == MODE_LOSSY) && in_beat && !sink_win;
      end
   end

   tie_ready_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE == MODE_TIE) |-> in_ready)
      else $error("upstream ready not held high without sink ready");

   loss_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE == MODE_LOSSY && in_beat && !sink_win) |=> data_lost_r)
      else $error("refused beat not flagged as lost");

   no_false_loss_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE != MODE_LOSSY || sink_win) |=> !data_lost_r)
      else $error("loss flagged for an accepted beat");

   // a look-back of zero cycles is no history at all, so equal latencies check live
   if (LAT_DIFF > 0) begin : g_delay_chk
      ready_delay_a: assert property (@(posedge ref_clk) disable iff (reset)
         (MODE == MODE_DELAY && settle_r >= BUF_DEPTH)
            |-> (in_ready == $past(out_ready, LAT_DIFF)))
         else $error("upstream ready not delayed by latency difference");
   end else begin : g_live_chk
      ready_live_a: assert property (@(posedge ref_clk) disable iff (reset)
         (MODE == MODE_DELAY) |-> (in_ready == out_ready))
         else $error("upstream ready not passed on at equal latency");
   end

   buf_bound_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE == MODE_BUFFER) |-> (count_r + pend <= BUF_DEPTH))
      else $error("compensation buffer may overflow");

   buf_window_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE == MODE_BUFFER && out_valid) |-> sink_win && count_r != CNT_RESET)
      else $error("beat driven outside sink window");

   buf_drain_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE == MODE_BUFFER && pop && !push) |=> (count_r == $past(count_r) - CNT_W'(1)))
      else $error("buffer count not reduced on drain");

   payload_pass_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE != MODE_BUFFER) |-> (out_data == in_data && out_channel == in_channel
                                 && out_error == in_error && out_empty == in_empty
                                 && out_startofpacket == in_startofpacket
                                 && out_endofpacket == in_endofpacket))
      else $error("payload not forwarded unchanged");

   valid_gen_a: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE != MODE_BUFFER && !IN_HAS_VALID) |-> out_valid)
      else $error("valid not generated for valid-less input");
endmodule

//--- testbench/sink_model.sv
/*
 * Partner model of the downstream sink: drives ready from a stall request.
 * Assumes it shares ref_clk with the adapter and has a ready latency of zero.
 */
`timescale 1ns/10ps
module sink_model (
   // clock
   input wire logic ref_clk,
   // handshake
   input wire logic stall,
   output logic ready
);
   initial ready = 1'b0;
   // ready only moves after an edge, as real sink logic would
   always @(posedge ref_clk) begin
      ready <= !stall;
   end
endmodule

//--- testbench/tb_stream_ready_latency_adapter.sv
/*
 * Testbench: delay-mode, lossy valid-less, tied-ready and buffering adapters behind one sink model.
 * Assumes the adapter package and the design are compiled first.
 */
`timescale 1ns/10ps
module tb_stream_ready_latency_adapter;
   import stream_adapt_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic in_valid = 1'b0;
   logic stall = 1'b1;
   logic [DATA_W-1:0] in_data = '0;
   logic u_ready, d_ready, d_valid, l_ready, l_valid, l_lost;
   logic [DATA_W-1:0] d_data;
   logic [CHANNEL_W-1:0] d_chan;
   logic b_valid = 1'b0;
   logic [DATA_W-1:0] b_data = '0;
   logic t_ready, t_valid, b_ready, b_out_valid;
   logic [DATA_W-1:0] b_out_data;
   int n_mismatch = 0;
   int n_compared = 0;
   initial forever #10 ref_clk = ~ref_clk;
   sink_model u_sink (.ref_clk(ref_clk), .stall(stall), .ready(u_ready));
   stream_ready_latency_adapter #(.IN_READY_LATENCY(0), .OUT_READY_LATENCY(2)) dut (
      .ref_clk(ref_clk), .reset(reset), .in_valid(in_valid), .in_ready(d_ready),
      .in_data(in_data), .in_channel(in_data[7:0]), .in_startofpacket(in_data[8]),
      .in_endofpacket(in_data[9]), .in_empty(in_data[11:10]), .in_error(in_data[12]),
      .out_valid(d_valid), .out_ready(u_ready), .out_data(d_data), .out_channel(d_chan),
      .out_startofpacket(), .out_endofpacket(), .out_empty(), .out_error(),
      .data_lost_r());
   // lossy instance also lacks valid, so every cycle is a beat
   stream_ready_latency_adapter #(.IN_HAS_READY(1'b0), .IN_HAS_VALID(1'b0)) u_lossy (
      .ref_clk(ref_clk), .reset(reset), .in_valid(in_valid), .in_ready(l_ready),
      .in_data(in_data), .in_channel(in_data[7:0]), .in_startofpacket(in_data[8]),
      .in_endofpacket(in_data[9]), .in_empty(in_data[11:10]), .in_error(in_data[12]),
      .out_valid(l_valid), .out_ready(u_ready), .out_data(), .out_channel(),
      .out_startofpacket(), .out_endofpacket(), .out_empty(), .out_error(),
      .data_lost_r(l_lost));
   // ready-less sink behind a ready-capable source: upstream ready is tied high
   stream_ready_latency_adapter #(.OUT_HAS_READY(1'b0)) u_tie (
      .ref_clk(ref_clk), .reset(reset), .in_valid(in_valid), .in_ready(t_ready),
      .in_data(in_data), .in_channel(in_data[7:0]), .in_startofpacket(in_data[8]),
      .in_endofpacket(in_data[9]), .in_empty(in_data[11:10]), .in_error(in_data[12]),
      .out_valid(t_valid), .out_ready(u_ready), .out_data(), .out_channel(),
      .out_startofpacket(), .out_endofpacket(), .out_empty(), .out_error(),
      .data_lost_r());
   // source answers two cycles after ready, sink at once: two-entry buffer
   stream_ready_latency_adapter #(.IN_READY_LATENCY(2), .OUT_READY_LATENCY(0)) u_buf (
      .ref_clk(ref_clk), .reset(reset), .in_valid(b_valid), .in_ready(b_ready),
      .in_data(b_data), .in_channel(b_data[7:0]), .in_startofpacket(b_data[8]),
      .in_endofpacket(b_data[9]), .in_empty(b_data[11:10]), .in_error(b_data[12]),
      .out_valid(b_out_valid), .out_ready(u_ready), .out_data(b_out_data),
      .out_channel(), .out_startofpacket(), .out_endofpacket(), .out_empty(),
      .out_error(), .data_lost_r());

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ready must reach the source exactly two cycles late; payload passes straight
   task automatic t_delay();
      logic [2:0] hist;
      logic [7:0] pat;
      hist = 3'h0;
      pat = 8'hB2;
      for (int i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         stall <= pat[i%8];
         in_valid <= 1'b1;
         in_data <= 32'hA5C3_1F00 + i;
         #1;
         hist = {hist[1:0], u_ready};
         check(d_ready, hist[2]);
         check(d_data, in_data);
         check(d_chan, in_data[7:0]);
         check(d_valid, 1'b1);
      end
      $display("test delay done");
   endtask

   // one refused cycle must give exactly one loss pulse, one cycle later
   task automatic t_lossy();
      @(posedge ref_clk);
      stall <= 1'b0;
      in_valid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      check(l_lost, 1'b0);
      check(l_ready, 1'b1);
      check(l_valid, 1'b1);
      check(t_ready, 1'b1);
      check(t_valid, 1'b0);
      @(posedge ref_clk) stall <= 1'b1;
      @(posedge ref_clk) stall <= 1'b0;
      @(posedge ref_clk) #1 check(l_lost, 1'b1);
      @(posedge ref_clk) #1 check(l_lost, 1'b0);
      $display("test lossy done");
   endtask

   // the source answers each grant two cycles later; beats must leave in order, none lost
   task automatic t_buffer();
      logic [1:0] g;
      logic [7:0] pat;
      int n_sent;
      int n_got;
      g = 2'h0;
      pat = 8'hB2;
      n_sent = 0;
      n_got = 0;
      for (int i = 0; i < 24; i++) begin
         @(posedge ref_clk);
         stall <= (i < 12) && pat[i%8];
         b_valid <= g[1] && (i < 14);
         b_data <= 32'h5A00 + n_sent;
         if (g[1] && i < 14) begin
            n_sent++;
         end
         #1;
         g = {g[0], b_ready};
         if (b_out_valid) begin
            check(u_ready, 1'b1);
            check(b_out_data, 32'h5A00 + n_got);
            n_got++;
         end
      end
      check(n_sent != 0, 1'b1);
      check(n_got, n_sent);
      $display("test buffer done");
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      #1 check(d_ready, 1'b0);
      check(l_lost, 1'b0);
      check(b_out_valid, 1'b0);
      @(posedge ref_clk) reset <= 1'b0;
      t_delay();
      t_lossy();
      t_buffer();
      close_out();
   end

   // whole run is under sixty cycles; over three times that is a hang
   initial begin
      #(20 * 200);
      n_mismatch++;
      close_out();
   end
endmodule
